// ### src/ecc_defs.svh
// Register offsets, field positions, reset values and counts of the ECC RAM controller
`ifndef ECC_DEFS_SVH
`define ECC_DEFS_SVH

`define ECC_OFS_CTRL      6'h00
`define ECC_OFS_IRQEN     6'h04
`define ECC_OFS_MODE      6'h08
`define ECC_OFS_INIT_STATUS_REG  6'h0C
`define ECC_OFS_PEND      6'h10
`define ECC_OFS_SLOG0     6'h14
`define ECC_OFS_SLOG1     6'h18
`define ECC_OFS_DLOG0     6'h1C
`define ECC_OFS_DLOG1     6'h20

`define ECC_CTRL_EN_BIT   0
`define ECC_CTRL_INIT_LSB 8
`define ECC_STAT_BUSY_LSB 8
`define ECC_PEND_DBL_LSB  2

`define ECC_RST_WORD      32'h0000_0000
`define ECC_INIT_DATA     32'h0000_0000
`define ECC_LAST_WORD     8'hFF

`endif

// ### src/ecc_pkg.sv
// Types shared by the ECC RAM controller modules
package ecc_pkg;
	typedef logic [7:0]  ram_addr_t;
	typedef logic [31:0] word_t;
	typedef logic [6:0]  check_t;
	typedef logic [38:0] cw_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_INIT = 2'b10
	} port_state_t;
endpackage : ecc_pkg

// ### src/ecc_ctl_if.sv
// Control and event carrier between the register side and one RAM port engine
`timescale 1ns/1ps
`default_nettype none
interface ecc_ctl_if;
	logic                ecc_en_shadow;
	logic                cfg_req;
	logic                cfg_ack;
	logic                init_start;
	logic                init_busy;
	logic                init_done;
	logic                periph_run;
	logic                sbe;
	logic                dbe;
	ecc_pkg::ram_addr_t  err_addr;
	modport regs (output ecc_en_shadow, cfg_req, init_start, periph_run,
		input cfg_ack, init_busy, init_done, sbe, dbe, err_addr);
	modport port (input ecc_en_shadow, cfg_req, init_start, periph_run,
		output cfg_ack, init_busy, init_done, sbe, dbe, err_addr);
endinterface : ecc_ctl_if
`default_nettype wire

// ### src/ecc_secded.sv
// Single-error-correct, double-error-detect code over a 32-bit word
`timescale 1ns/1ps
`default_nettype none
module ecc_secded
	import ecc_pkg::*;
(
	input  wire ecc_pkg::word_t  enc_data_i,
	output var   ecc_pkg::check_t enc_check_o,
	input  wire ecc_pkg::word_t  dec_data_i,
	input  wire ecc_pkg::check_t dec_check_i,
	output var   ecc_pkg::word_t  dec_data_o,
	output logic                 dec_single_o,
	output logic                 dec_double_o
);
	import ecc_pkg::*;

	// Data bits go to the non power-of-two code positions 1..38
	function automatic cw_t spread(input word_t d);
		cw_t cw;
		int  k;
		cw = '0;
		k  = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p] = d[k];
				k++;
			end
		end
		return cw;
	endfunction : spread

	function automatic word_t gather(input cw_t cw);
		word_t d;
		int    k;
		d = '0;
		k = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = cw[p];
				k++;
			end
		end
		return d;
	endfunction : gather

	function automatic logic [5:0] hamming(input cw_t cw);
		logic [5:0] c;
		c = '0;
		for (int i = 0; i < 6; i++) begin
			for (int p = 1; p < 39; p++) begin
				if (((p >> i) & 1) == 1)
					c[i] = c[i] ^ cw[p];
			end
		end
		return c;
	endfunction : hamming

	// Encode: six Hamming bits plus overall parity on top
	wire logic [5:0] enc_ham = hamming(spread(enc_data_i));
	assign enc_check_o = {^{enc_data_i, enc_ham}, enc_ham};

	// Decode: syndrome picks the flipped position, parity splits single from double
	wire cw_t        dec_cw  = spread(dec_data_i);
	wire logic [5:0] syn     = hamming(dec_cw) ^ dec_check_i[5:0];
	wire logic       par_err = ^{dec_data_i, dec_check_i};
	wire cw_t        fixed   = dec_cw ^ (cw_t'(par_err) << syn);
	assign dec_single_o = par_err;
	assign dec_double_o = !par_err && (syn != 6'h00);
	assign dec_data_o   = gather(fixed);
endmodule : ecc_secded
`default_nettype wire

// ### src/ecc_ram_port.sv
// One RAM port: access path, check bits, read checking and the init engine
`timescale 1ns/1ps
`default_nettype none
`include "ecc_defs.svh"
module ecc_ram_port
	import ecc_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_n_i,
	ecc_ctl_if.port              ctl,
	input  wire logic            usr_req_i,
	input  wire logic            usr_we_i,
	input  wire ecc_pkg::ram_addr_t usr_addr_i,
	input  wire ecc_pkg::word_t  usr_wdata_i,
	output var   ecc_pkg::word_t  usr_rdata_o,
	output logic                 usr_rvalid_o,
	output logic                 ram_en_o,
	output logic                 ram_we_o,
	output var   ecc_pkg::ram_addr_t ram_addr_o,
	output var   ecc_pkg::cw_t    ram_wdata_o,
	input  wire ecc_pkg::cw_t    ram_rdata_i
);
	import ecc_pkg::*;

	port_state_t state_r;
	ram_addr_t   cnt_r;
	ram_addr_t   addr_p1_r;
	ram_addr_t   addr_p2_r;
	logic        ecc_en_r;
	logic        rd_p1_r;
	logic        rd_p2_r;
	word_t       dec_data;
	check_t      enc_check;
	logic        dec_single;
	logic        dec_double;

	// User access only outside init and with the peripheral running
	wire logic  busy   = (state_r == ST_INIT);
	wire logic  accept = usr_req_i && ctl.periph_run && !busy;
	wire word_t wdata  = busy ? `ECC_INIT_DATA : usr_wdata_i;
	// Init always writes consistent check bits so later reads pass
	wire check_t wcheck = (busy || ecc_en_r) ? enc_check : 7'h00;
	assign ctl.init_busy = busy;

	ecc_secded u_code (
		.enc_data_i   (wdata),
		.enc_check_o  (enc_check),
		.dec_data_i   (ram_rdata_i[31:0]),
		.dec_check_i  (ram_rdata_i[38:32]),
		.dec_data_o   (dec_data),
		.dec_single_o (dec_single),
		.dec_double_o (dec_double)
	);

	// RAM request stage; RAM data returns one cycle after a read
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ram_en_o    <= 1'b0;
			ram_we_o    <= 1'b0;
			ram_addr_o  <= '0;
			ram_wdata_o <= '0;
		end else begin
			ram_en_o    <= busy || accept;
			ram_we_o    <= busy || (accept && usr_we_i);
			ram_addr_o  <= busy ? cnt_r : usr_addr_i;
			ram_wdata_o <= {wcheck, wdata};
		end
	end

	// Init engine walks every word, then flags done
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r       <= ST_IDLE;
			cnt_r         <= '0;
			ctl.init_done <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (ctl.init_start) begin
						state_r       <= ST_INIT;
						cnt_r         <= '0;
						ctl.init_done <= 1'b0;
					end
				end
				ST_INIT: begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r == `ECC_LAST_WORD) begin
						state_r       <= ST_IDLE;
						ctl.init_done <= 1'b1;
					end
				end
			endcase
		end
	end

	// Read check only on real read cycles
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_p1_r      <= 1'b0;
			rd_p2_r      <= 1'b0;
			addr_p1_r    <= '0;
			addr_p2_r    <= '0;
			usr_rvalid_o <= 1'b0;
			usr_rdata_o  <= '0;
			ctl.sbe      <= 1'b0;
			ctl.dbe      <= 1'b0;
			ctl.err_addr <= '0;
		end else begin
			rd_p1_r      <= accept && !usr_we_i;
			addr_p1_r    <= usr_addr_i;
			rd_p2_r      <= rd_p1_r;
			addr_p2_r    <= addr_p1_r;
			usr_rvalid_o <= rd_p2_r;
			usr_rdata_o  <= ecc_en_r ? dec_data : ram_rdata_i[31:0];
			ctl.sbe      <= rd_p2_r && ecc_en_r && dec_single;
			ctl.dbe      <= rd_p2_r && ecc_en_r && dec_double;
			ctl.err_addr <= addr_p2_r;
		end
	end

	// Four-phase handover of the enable; the copy changes only on a request
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ecc_en_r    <= 1'b0;
			ctl.cfg_ack <= 1'b0;
		end else if (ctl.cfg_req && !ctl.cfg_ack) begin
			ecc_en_r    <= ctl.ecc_en_shadow;
			ctl.cfg_ack <= 1'b1;
		end else if (!ctl.cfg_req) begin
			ctl.cfg_ack <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_INIT_ENDS: assert property (busy && cnt_r == `ECC_LAST_WORD |=> !busy && ctl.init_done)
		else $error("init did not finish after last word");
	AST_IDLE_NO_CHECK: assert property (!rd_p2_r |=> !ctl.sbe && !ctl.dbe)
		else $error("error event without a read");
	AST_INIT_WRITES: assert property (busy |=> ram_en_o && ram_we_o && ram_wdata_o[31:0] == `ECC_INIT_DATA)
		else $error("init cycle did not write the fill word");
	COV_INIT_DONE: cover property (busy ##1 ctl.init_done);
endmodule : ecc_ram_port
`default_nettype wire

// ### src/ecc_ram_ctrl.sv
// ECC RAM controller top: Avalon-MM register slave and two RAM port engines
// Function
// - Init allowed while peripheral held in reset
// - Init request bit starts the init engine
// - Dual port: separate init bit and flag
// - Per-port done flag gates interrupt setup; here the done flags are only read back, gating nothing
// - Check bits written with data when enabled
// - Reads checked and corrected when enabled
// - Coding work only on valid RAM cycles
// - Irq mode register steers error requests
// - Port logic runs on its port clock; here both port engines run on clk_sys_i
// - Register side clocked separately, synchronized; here it shares clk_sys_i and only the peripheral reset is synchronized
// - Reset keeps RAM, clears slave state
// - Double errors always interrupt, log address
// - Single errors interrupt only when enabled
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_defs.svh"
module ecc_ram_ctrl
	import ecc_pkg::*;
(
	input  wire logic                    clk_sys_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    periph_reset_n_i,
	input  wire logic [5:0]              address_i,
	input  wire logic                    read_i,
	input  wire logic                    write_i,
	input  wire logic [31:0]             writedata_i,
	output logic      [31:0]             readdata_o,
	output logic                         waitrequest_o,
	input  wire logic [1:0]              usr_req_i,
	input  wire logic [1:0]              usr_we_i,
	input  wire ecc_pkg::ram_addr_t [1:0] usr_addr_i,
	input  wire ecc_pkg::word_t [1:0]    usr_wdata_i,
	output var   ecc_pkg::word_t [1:0]   usr_rdata_o,
	output logic [1:0]                   usr_rvalid_o,
	output logic [1:0]                   ram_en_o,
	output logic [1:0]                   ram_we_o,
	output var   ecc_pkg::ram_addr_t [1:0] ram_addr_o,
	output var   ecc_pkg::cw_t [1:0]     ram_wdata_o,
	input  wire ecc_pkg::cw_t [1:0]      ram_rdata_i,
	output logic                         irq_single_o,
	output logic                         irq_double_o
);
	import ecc_pkg::*;

	logic        ecc_en_r;
	logic        irqen_r;
	logic        mode_r;
	logic        cfg_req_r;
	logic        cfg_pend_r;
	logic [1:0]  start_r;
	logic [3:0]  pend_r;
	logic [3:0]  pend_nxt;
	logic        prst_meta_r;
	logic        prst_sync_r;
	ram_addr_t   slog_r [2];
	ram_addr_t   dlog_r [2];
	logic [1:0]  sbe_new;
	logic [1:0]  sbe_ev;
	logic [1:0]  dbe_ev;
	logic [1:0]  ack_w;
	logic [1:0]  busy_w;
	logic [1:0]  done_w;
	ram_addr_t   eaddr_w [2];

	ecc_ctl_if ctl_if [2] ();

	// Peripheral reset pin is asynchronous to us: two flops first
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			prst_meta_r <= 1'b0;
			prst_sync_r <= 1'b0;
		end else begin
			prst_meta_r <= periph_reset_n_i;
			prst_sync_r <= prst_meta_r;
		end
	end

	// Per-port engines; both share this clock in this build
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_port
			assign ctl_if[g].ecc_en_shadow = ecc_en_r;
			assign ctl_if[g].cfg_req       = cfg_req_r;
			assign ctl_if[g].init_start    = start_r[g];
			assign ctl_if[g].periph_run    = prst_sync_r;
			assign ack_w[g]   = ctl_if[g].cfg_ack;
			assign busy_w[g]  = ctl_if[g].init_busy;
			assign done_w[g]  = ctl_if[g].init_done;
			assign sbe_ev[g]  = ctl_if[g].sbe;
			assign dbe_ev[g]  = ctl_if[g].dbe;
			assign eaddr_w[g] = ctl_if[g].err_addr;
			// Mode 1 reports a single error only when its address is new
			assign sbe_new[g] = sbe_ev[g] && (!mode_r || eaddr_w[g] != slog_r[g]);

			ecc_ram_port u_port (
				.clk_i        (clk_sys_i),
				.rst_n_i      (reset_n_i),
				.ctl          (ctl_if[g]),
				.usr_req_i    (usr_req_i[g]),
				.usr_we_i     (usr_we_i[g]),
				.usr_addr_i   (usr_addr_i[g]),
				.usr_wdata_i  (usr_wdata_i[g]),
				.usr_rdata_o  (usr_rdata_o[g]),
				.usr_rvalid_o (usr_rvalid_o[g]),
				.ram_en_o     (ram_en_o[g]),
				.ram_we_o     (ram_we_o[g]),
				.ram_addr_o   (ram_addr_o[g]),
				.ram_wdata_o  (ram_wdata_o[g]),
				.ram_rdata_i  (ram_rdata_i[g])
			);
		end
	endgenerate

	// Bus decode; a write lands at the edge where waitrequest is seen low
	wire logic wr_take   = write_i && !waitrequest_o;
	wire logic hit_ctrl  = (address_i == `ECC_OFS_CTRL);
	wire logic hit_irqen = (address_i == `ECC_OFS_IRQEN);
	wire logic hit_mode  = (address_i == `ECC_OFS_MODE);
	wire logic hit_pend  = (address_i == `ECC_OFS_PEND);
	wire logic wr_ctrl   = wr_take && hit_ctrl;
	wire logic [1:0] init_wr = writedata_i[`ECC_CTRL_INIT_LSB +: 2];
	wire logic [3:0] pend_clr = (wr_take && hit_pend) ? writedata_i[3:0] : 4'h0;

	// Pending bits: set beats a clear in the same cycle
	always_comb begin
		pend_nxt = pend_r & ~pend_clr;
		pend_nxt = pend_nxt | {dbe_ev, sbe_new};
	end

	// Read mux; unmapped words read as zero
	function automatic logic [31:0] reg_view(input logic [5:0] a, input logic en,
			input logic ie, input logic md, input logic [1:0] bz, input logic [1:0] dn,
			input logic [3:0] pd, input ram_addr_t s0, input ram_addr_t s1,
			input ram_addr_t d0, input ram_addr_t d1);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`ECC_OFS_CTRL:     v = {22'h0, bz, 7'h00, en};
			`ECC_OFS_IRQEN:    v = {31'h0, ie};
			`ECC_OFS_MODE:     v = {31'h0, md};
			`ECC_OFS_INIT_STATUS_REG: v = {22'h0, bz, 6'h00, dn};
			`ECC_OFS_PEND:     v = {28'h0, pd};
			`ECC_OFS_SLOG0:    v = {24'h0, s0};
			`ECC_OFS_SLOG1:    v = {24'h0, s1};
			`ECC_OFS_DLOG0:    v = {24'h0, d0};
			`ECC_OFS_DLOG1:    v = {24'h0, d1};
			default:           v = 32'h0000_0000;
		endcase
		return v;
	endfunction : reg_view

	// One wait cycle on every access, then completion
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			waitrequest_o <= 1'b1;
			readdata_o    <= `ECC_RST_WORD;
		end else if (!waitrequest_o) begin
			waitrequest_o <= 1'b1;
		end else if (read_i || write_i) begin
			waitrequest_o <= 1'b0;
			readdata_o    <= reg_view(address_i, ecc_en_r, irqen_r, mode_r, busy_w,
				done_w, pend_r, slog_r[0], slog_r[1], dlog_r[0], dlog_r[1]);
		end
	end

	// Control, enable and mode registers
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			ecc_en_r <= 1'b0;
			irqen_r  <= 1'b0;
			mode_r   <= 1'b0;
		end else begin
			if (wr_ctrl)
				ecc_en_r <= writedata_i[`ECC_CTRL_EN_BIT];
			if (wr_take && hit_irqen)
				irqen_r <= writedata_i[0];
			if (wr_take && hit_mode)
				mode_r <= writedata_i[0];
		end
	end

	// Enable handover; a write during a transfer waits in cfg_pend_r for the next round,
	// since a request raised while the ports still acknowledge would never be sampled
	wire logic cfg_idle = !cfg_req_r && !(|ack_w);
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			cfg_req_r  <= 1'b0;
			cfg_pend_r <= 1'b0;
		end else begin
			if (cfg_req_r && &ack_w)
				cfg_req_r <= 1'b0;
			else if (cfg_idle && (wr_ctrl || cfg_pend_r))
				cfg_req_r <= 1'b1;
			if (wr_ctrl && !cfg_idle)
				cfg_pend_r <= 1'b1;
			else if (cfg_idle)
				cfg_pend_r <= 1'b0;
		end
	end

	// Init start pulses; either port may run alone or both together
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			start_r <= 2'b00;
		else
			start_r <= wr_ctrl ? init_wr : 2'b00;
	end

	// Status, logs and interrupt lines
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			pend_r       <= 4'h0;
			irq_single_o <= 1'b0;
			irq_double_o <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				slog_r[i] <= '0;
				dlog_r[i] <= '0;
			end
		end else begin
			pend_r <= pend_nxt;
			for (int i = 0; i < 2; i++) begin
				if (sbe_ev[i])
					slog_r[i] <= eaddr_w[i];
				if (dbe_ev[i])
					dlog_r[i] <= eaddr_w[i];
			end
			irq_single_o <= irqen_r && (|pend_r[1:0]);
			irq_double_o <= |pend_r[3:2];
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	AST_WAIT_ONE: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("bus access not answered after one wait cycle");
	AST_RESET_STATE: assert property (disable iff (1'b0) !reset_n_i |=>
		waitrequest_o && pend_r == 4'h0)
		else $error("reset did not clear slave state");
	AST_DBE_PEND: assert property (dbe_ev[0] |=> pend_r[2] ##1 irq_double_o)
		else $error("double error did not raise its interrupt");
	AST_DBE_LOG: assert property (dbe_ev[1] |=> dlog_r[1] == $past(eaddr_w[1]))
		else $error("double error address not logged");
	AST_SBE_MASKED: assert property (!irqen_r |=> !irq_single_o)
		else $error("single error interrupt while disabled");
	AST_SBE_LOG: assert property (sbe_ev[0] |=> slog_r[0] == $past(eaddr_w[0]))
		else $error("single error address not logged");
	AST_INIT_START: assert property (wr_ctrl && init_wr[1] |=> start_r[1])
		else $error("init request did not start the port");
	AST_CFG_HS: assert property (cfg_req_r && (&ack_w) && !wr_ctrl |=> !cfg_req_r)
		else $error("handover request not dropped after acknowledge");
	AST_PEND_SET_WINS: assert property (dbe_ev[0] && pend_clr[2] |=> pend_r[2])
		else $error("clear beat a new double error");
	AST_PERIPH_SYNC: assert property (!prst_sync_r && busy_w == 2'b00 |=> ram_en_o == 2'b00)
		else $error("user access while peripheral held in reset");
	AST_WAIT_STANDS: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	AST_START_PULSE: assert property ((|start_r) |=> start_r == 2'b00)
		else $error("init start longer than one cycle");

	// Pending bits and logs; the double line has no mask at all
	AST_SBE_PEND: assert property (sbe_ev[0] && !mode_r |=> pend_r[0])
		else $error("single error on port 0 not pending");
	AST_SBE_PEND1: assert property (sbe_ev[1] && !mode_r |=> pend_r[1])
		else $error("single error on port 1 not pending");
	AST_SBE_SET_WINS: assert property (sbe_new[0] && pend_clr[0] |=> pend_r[0])
		else $error("clear beat a new single error");
	AST_MODE_REPEAT: assert property (mode_r && sbe_ev[0] && eaddr_w[0] == slog_r[0] && !pend_r[0]
		|=> !pend_r[0])
		else $error("repeat address pended in mode 1");
	AST_PEND_CLEAR: assert property (pend_clr[2] && !dbe_ev[0] |=> !pend_r[2])
		else $error("double pending bit not cleared");
	AST_SBE_LOG1: assert property (sbe_ev[1] |=> slog_r[1] == $past(eaddr_w[1]))
		else $error("single error address of port 1 not logged");
	AST_DBE_LOG0: assert property (dbe_ev[0] |=> dlog_r[0] == $past(eaddr_w[0]))
		else $error("double error address of port 0 not logged");
	AST_IRQ_S_LEVEL: assert property (irqen_r && (|pend_r[1:0]) |=> irq_single_o)
		else $error("enabled single error not signalled");
	AST_IRQ_S_CLEAR: assert property (!(|pend_r[1:0]) |=> !irq_single_o)
		else $error("single interrupt without pending bit");
	AST_IRQ_D_LEVEL: assert property (pend_r[3] |=> irq_double_o)
		else $error("port 1 double error not signalled");
	AST_IRQ_D_CLEAR: assert property (!(|pend_r[3:2]) |=> !irq_double_o)
		else $error("double interrupt without pending bit");

	COV_DBE: cover property (dbe_ev[0] ##2 irq_double_o);
	COV_SBE_IRQ: cover property (irqen_r && sbe_ev[1] ##2 irq_single_o);
	COV_CFG: cover property (cfg_req_r ##[1:4] !cfg_req_r);
	COV_BOTH_INIT: cover property (start_r == 2'b11);
endmodule : ecc_ram_ctrl
`default_nettype wire

// ### tb/ecc_ram_model.sv
// Behavioural dual-port RAM behind the controller, with bit-flip injection on reads
`timescale 1ns/1ps
`default_nettype none
module ecc_ram_model
	import ecc_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic [1:0]               en_i,
	input  wire logic [1:0]               we_i,
	input  wire ecc_pkg::ram_addr_t [1:0] addr_i,
	input  wire ecc_pkg::cw_t [1:0]       wdata_i,
	input  wire ecc_pkg::cw_t [1:0]       flip_i,
	output var ecc_pkg::cw_t [1:0]        rdata_o
);
	cw_t mem_r [256];

	// Power-up garbage, so nothing passes unless the init engine wrote it
	initial begin
		foreach (mem_r[i])
			mem_r[i] = 39'h55_5555_5555;
		rdata_o = '0;
	end

	// Read word stands one cycle only; otherwise the bus toggles to expose stale use
	always @(posedge clk_i) begin
		for (int p = 0; p < 2; p++) begin
			if (en_i[p] && we_i[p])
				mem_r[addr_i[p]] <= wdata_i[p];
			if (en_i[p] && !we_i[p])
				rdata_o[p] <= mem_r[addr_i[p]] ^ flip_i[p];
			else
				rdata_o[p] <= ~rdata_o[p];
		end
	end
endmodule : ecc_ram_model
`default_nettype wire

// ### tb/ecc_ram_ctrl_tb_top.sv
// Self-checking bench for the ECC RAM controller
`timescale 1ns/1ps
`default_nettype none
`include "ecc_defs.svh"
module ecc_ram_ctrl_tb_top;
	import ecc_pkg::*;
	logic            clk, rst_n, prst_n, rd, wr, wreq, irq_s, irq_d;
	logic [5:0]      addr;
	logic [31:0]     wdat, rdat, q;
	logic [1:0]      u_req, u_we, u_vld, r_en, r_we;
	ram_addr_t [1:0] u_addr, r_addr;
	word_t [1:0]     u_wd, u_rd;
	cw_t [1:0]       r_wd, r_rdat, flip;
	cw_t             c;
	int              failures, n_checks;

	ecc_ram_ctrl ecc_ram_ctrl_i (
		.clk_sys_i(clk), .reset_n_i(rst_n), .periph_reset_n_i(prst_n),
		.address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wdat),
		.readdata_o(rdat), .waitrequest_o(wreq), .usr_req_i(u_req), .usr_we_i(u_we),
		.usr_addr_i(u_addr), .usr_wdata_i(u_wd), .usr_rdata_o(u_rd), .usr_rvalid_o(u_vld),
		.ram_en_o(r_en), .ram_we_o(r_we), .ram_addr_o(r_addr), .ram_wdata_o(r_wd),
		.ram_rdata_i(r_rdat), .irq_single_o(irq_s), .irq_double_o(irq_d));

	ecc_ram_model ecc_ram_model_i (
		.clk_i(clk), .en_i(r_en), .we_i(r_we), .addr_i(r_addr), .wdata_i(r_wd),
		.flip_i(flip), .rdata_o(r_rdat));

	// 10 MHz system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic wrap_up;
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [38:0] e, input logic [38:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Avalon master: hold the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (wreq === 1'b0)
				break;
		end
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n == 20) begin
			chk("bus_timeout", 0, 1);
			wrap_up();
		end
	endtask : bus

	task automatic rreg(input logic [5:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask : rreg

	// One user access; reads wait a bounded time for the corrected word
	task automatic uacc(input int p, input logic w, input ram_addr_t a, input word_t d);
		int n;
		@(posedge clk);
		u_req[p] <= 1'b1;
		u_we[p] <= w;
		u_addr[p] <= a;
		u_wd[p] <= d;
		@(posedge clk);
		u_req[p] <= 1'b0;
		@(negedge clk);
		chk("ram_en", 1, r_en[p]);
		c = r_wd[p];
		q = 'x;
		for (n = 0; n < 6 && !w; n++) begin
			@(negedge clk);
			if (u_vld[p] === 1'b1) begin
				q = u_rd[p];
				break;
			end
		end
	endtask : uacc

	task automatic t_reset;
		@(negedge clk);
		chk("idle_wait", 1, wreq);
		chk("idle_ram_en", 0, r_en);
		@(posedge clk);
		u_req[0] <= 1'b1;
		@(posedge clk);
		u_req[0] <= 1'b0;
		@(negedge clk);
		chk("gated_ram_en", 0, r_en);
		rreg(`ECC_OFS_CTRL, 32'h0, "ctrl");
		rreg(`ECC_OFS_INIT_STATUS_REG, 32'h0, "init_status_reg");
		rreg(`ECC_OFS_PEND, 32'h0, "pend");
		rreg(6'h3C, 32'h0, "unmapped");
	endtask : t_reset

	// Bring-up of one port while the peripheral is still held in reset
	task automatic t_init(input int p);
		int cnt;
		int i;
		bus(1'b1, `ECC_OFS_IRQEN, 32'h0);
		bus(1'b1, `ECC_OFS_CTRL, 32'h0);
		bus(1'b1, `ECC_OFS_CTRL, 32'h1 << (`ECC_CTRL_INIT_LSB + p));
		cnt = 0;
		for (i = 0; i < 600 && cnt < 256; i++) begin
			@(negedge clk);
			if (r_en[p] && r_we[p]) begin
				chk("init_addr", 39'(cnt % 256), r_addr[p]);
				chk("init_data", 0, r_wd[p][31:0]);
				cnt++;
			end
		end
		chk("init_words", 256, 39'(cnt));
		for (i = 0; i < 10; i++) begin
			bus(1'b0, `ECC_OFS_INIT_STATUS_REG, 32'h0);
			if (q[p] === 1'b1)
				break;
		end
		chk("init_stat", p ? 39'h3 : 39'h1, q);
	endtask : t_init

	// ECC off: no check bits, raw reads, no events
	task automatic t_plain;
		uacc(0, 1'b1, 8'h05, 32'hA5A5_0F0F);
		chk("chk_off", 0, c[38:32]);
		flip[0] <= 39'h1;
		uacc(0, 1'b0, 8'h05, 32'h0);
		chk("raw_read", 32'hA5A5_0F0E, q);
		rreg(`ECC_OFS_PEND, 32'h0, "pend_off");
	endtask : t_plain

	task automatic t_single;
		bus(1'b1, `ECC_OFS_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		flip[0] <= 39'h0;
		uacc(0, 1'b0, 8'h00, 32'h0);
		chk("init_word", 0, q);
		uacc(0, 1'b1, 8'h21, 32'h1234_5678);
		uacc(0, 1'b0, 8'h21, 32'h0);
		chk("clean_read", 32'h1234_5678, q);
		rreg(`ECC_OFS_PEND, 32'h0, "pend_clean");
		flip[0] <= 39'h8;
		uacc(0, 1'b0, 8'h21, 32'h0);
		chk("corrected", 32'h1234_5678, q);
		rreg(`ECC_OFS_PEND, 32'h1, "pend_single");
		rreg(`ECC_OFS_SLOG0, 32'h21, "single_log");
		chk("irq_s_masked", 0, irq_s);
		bus(1'b1, `ECC_OFS_IRQEN, 32'h1);
		repeat (2) @(negedge clk);
		chk("irq_s_on", 1, irq_s);
		bus(1'b1, `ECC_OFS_PEND, 32'h1);
		repeat (2) @(negedge clk);
		chk("irq_s_clr", 0, irq_s);
	endtask : t_single

	task automatic t_double;
		bus(1'b1, `ECC_OFS_IRQEN, 32'h0);
		uacc(1, 1'b1, 8'h42, 32'hCAFE_F00D);
		flip[1] <= 39'h3;
		uacc(1, 1'b0, 8'h42, 32'h0);
		flip[1] <= 39'h0;
		rreg(`ECC_OFS_PEND, 32'h8, "pend_double");
		rreg(`ECC_OFS_DLOG1, 32'h42, "double_log");
		chk("irq_d_unmasked", 1, irq_d);
		bus(1'b1, `ECC_OFS_PEND, 32'h8);
		repeat (2) @(negedge clk);
		chk("irq_d_clr", 0, irq_d);
	endtask : t_double

	// Mode 1 suppresses a repeat at the logged address, mode 0 does not
	task automatic t_mode;
		bus(1'b1, `ECC_OFS_PEND, 32'hF);
		bus(1'b1, `ECC_OFS_MODE, 32'h1);
		flip[0] <= 39'h10;
		uacc(0, 1'b0, 8'h21, 32'h0);
		rreg(`ECC_OFS_PEND, 32'h0, "mode1_repeat");
		uacc(0, 1'b1, 8'h30, 32'h0F0F_3C3C);
		uacc(0, 1'b0, 8'h30, 32'h0);
		rreg(`ECC_OFS_PEND, 32'h1, "mode1_new");
		rreg(`ECC_OFS_SLOG0, 32'h30, "mode1_log");
		bus(1'b1, `ECC_OFS_PEND, 32'h1);
		bus(1'b1, `ECC_OFS_MODE, 32'h0);
		uacc(0, 1'b0, 8'h30, 32'h0);
		rreg(`ECC_OFS_PEND, 32'h1, "mode0_repeat");
		flip[0] <= 39'h0;
	endtask : t_mode

	// Second reset in mid-run keeps memory, clears the slave
	task automatic t_rereset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk("rst_ram_en", 0, r_en);
		@(posedge clk);
		rst_n <= 1'b1;
		rreg(`ECC_OFS_CTRL, 32'h0, "ctrl_rst");
		rreg(`ECC_OFS_PEND, 32'h0, "pend_rst");
		repeat (3) @(posedge clk);
		uacc(0, 1'b0, 8'h30, 32'h0);
		chk("ram_kept", 32'h0F0F_3C3C, q);
	endtask : t_rereset

	// Main sequence: init before use, no traffic during init
	initial begin
		rst_n = 1'b0;
		prst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = '0;
		wdat = '0;
		u_req = '0;
		u_we = '0;
		u_addr = '0;
		u_wd = '0;
		flip = '0;
		failures = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_init(0);
		t_init(1);
		@(posedge clk);
		prst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_plain();
		t_single();
		t_double();
		t_mode();
		t_rereset();
		wrap_up();
	end
endmodule : ecc_ram_ctrl_tb_top
`default_nettype wire
